// ---- logic/ids_core.sv ----
`include "ids_params.svh"
`default_nettype none

// Overview of operation
// - and class ands source with aux
// - xor class xors source with aux
// - load_literal writes literal to destination
// - execute_indirect sets low address bits, pc kept
// - taken branch_if_nonzero loads literal into pc, address
// - jump_absolute loads target into pc and address
// - otherwise pc increments and feeds address
// - three-bit opcode selects eight classes
// - five-bit operand codes, aux implicit second operand
// - operand code map for registers and carry
// - bank-select codes read as zero
// - rotate/length field meaning depends on operands
// - register to register right-rotate on bus
// - io source rotated then masked to length
// - io destination shifted, masked, merged with bus input data
// - one length serves source and destination
// - io to io merges into source bus data
// - literal eight bits for register, five io
// - thirteen-bit jump target spans whole storage
// - io code N rotates or shifts seven minus N
// - octal 2 left bank, 3 right bank
// - bank-select write drives bus with select strobe
module ids_core
  import ids_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  // program storage
  output var  logic [12:0] prog_addr,
  input  wire logic [15:0] instr_word,
  // i/o bus
  input  wire logic [7:0]  io_in,
  output var  ids_io_s     io_out
);

  // ==========================================================
  // apb register file
  logic        pready_ff;
  logic        nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        run_ff;
  logic        nxt_run;

  ids_state_e  state_ff;
  ids_state_e  nxt_state;
  logic [12:0] pc_ff;
  logic [12:0] nxt_pc;
  logic [12:0] addr_ff;
  logic [12:0] nxt_addr;
  logic [7:0]  regs_ff [8];
  logic [7:0]  nxt_regs [8];
  logic        carry_ff;
  logic        nxt_carry;
  ids_io_s     io_ff;
  ids_io_s     nxt_io;

  always_comb
  begin
    nxt_pready  = psel & ~penable & ~pready_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_run     = run_ff;
    if (psel && !penable)
    begin
      nxt_prdata = `IDS_WORD_ZERO;
      case (paddr)
        `IDS_OFF_CTRL:   nxt_prdata[`IDS_CTRL_RUN] = run_ff;
        `IDS_OFF_STATUS: nxt_prdata = {state_ff != ST_IDLE, 2'h0, addr_ff, 3'h0, pc_ff};
        `IDS_OFF_DATA:   nxt_prdata = {23'h00_0000, carry_ff, regs_ff[0]};
        default:         nxt_pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pready_ff && pwrite && paddr == `IDS_OFF_CTRL)
    begin
      nxt_run = pwdata[`IDS_CTRL_RUN];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= `IDS_WORD_ZERO;
      pslverr_ff <= 1'b0;
      run_ff     <= 1'b0;
    end
    else
    begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      run_ff     <= nxt_run;
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  // error flag is only ever set alongside the ready pulse, so it can leave the flop directly
  assign pslverr = pslverr_ff;

  // ==========================================================
  // decode and execute
  logic [2:0] op;
  logic [4:0] scode;
  logic [4:0] dcode;
  logic [2:0] rl;
  logic       src_io;
  logic       dst_io;
  logic       writes;
  logic [4:0] bcode;
  logic [7:0] jval;
  logic [7:0] rdata;
  logic [7:0] sdata;
  logic [8:0] sum;
  logic [7:0] alu;
  logic [7:0] dmask;
  logic [7:0] dshift;
  logic [7:0] merged;

  always_comb
  begin
    op     = instr_word[15:13];
    scode  = instr_word[12:8];
    rl     = instr_word[7:5];
    dcode  = (op == `IDS_OP_LOAD_LIT) ? instr_word[12:8] : instr_word[4:0];
    writes = (op == `IDS_OP_MOVE) || (op == `IDS_OP_ADD) || (op == `IDS_OP_AND)
          || (op == `IDS_OP_XOR) || (op == `IDS_OP_LOAD_LIT);
    src_io = scode[4] && (op != `IDS_OP_LOAD_LIT) && (op != `IDS_OP_JUMP_ABS);
    dst_io = dcode[4] && writes;
    // literal width follows whether an io field is named
    jval   = (src_io || (op == `IDS_OP_LOAD_LIT && dcode[4])) ?
             {3'h0, instr_word[4:0]} : instr_word[7:0];
    // input phase enables the source bank, else the destination bank for merging
    bcode  = src_io ? scode : (dst_io ? dcode : 5'h00);
    // register read with code map
    rdata  = `IDS_BYTE_ZERO;
    case (scode[4:3])
      `IDS_GRP_LOW:
      begin
        if (scode[2:0] != `IDS_IDX_NONE)
        begin
          rdata = regs_ff[scode[2:0]];
        end
      end
      `IDS_GRP_HIGH:
      begin
        if (scode == `IDS_CODE_CARRY)
        begin
          rdata = {7'h00, carry_ff};
        end
        else if (scode == `IDS_CODE_WREG9)
        begin
          rdata = regs_ff[`IDS_IDX_WREG9];
        end
      end
      default: rdata = `IDS_BYTE_ZERO;
    endcase
    // bank-select and unassigned codes fall through as zero
    if (src_io)
    begin
      sdata = ids_rotr(io_in, ~scode[2:0]) & ids_lmask(rl);
    end
    else if (!dst_io && writes && op != `IDS_OP_LOAD_LIT)
    begin
      sdata = ids_rotr(rdata, rl);
    end
    else
    begin
      sdata = rdata;
    end
    sum = {1'b0, sdata} + {1'b0, regs_ff[0]};
    case (op)
      `IDS_OP_ADD:      alu = sum[7:0];
      `IDS_OP_AND:      alu = sdata & regs_ff[0];
      `IDS_OP_XOR:      alu = sdata ^ regs_ff[0];
      `IDS_OP_EXEC_IND: alu = sdata + jval;
      `IDS_OP_LOAD_LIT: alu = jval;
      default:          alu = sdata;
    endcase
    // one length value masks both ends
    dmask  = ids_lmask(rl) << ~dcode[2:0];
    dshift = alu << ~dcode[2:0];
    // base is the bus data read in the input phase
    merged = (io_in & ~dmask) | (dshift & dmask);
  end

  // ==========================================================
  // sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_addr  = addr_ff;
    nxt_regs  = regs_ff;
    nxt_carry = carry_ff;
    nxt_io    = io_ff;
    case (state_ff)
      ST_IDLE, ST_OUT:
      begin
        nxt_io.oe                    = 1'b0;
        nxt_io.write_command         = 1'b0;
        nxt_io.select_command_strobe = 1'b0;
        nxt_io.left_bank_enable_n    = 1'b1;
        nxt_io.right_bank_enable_n   = 1'b1;
        if (run_ff)
        begin
          nxt_state                  = ST_IN;
          nxt_io.left_bank_enable_n  = (bcode[4:3] != `IDS_GRP_LEFT);
          nxt_io.right_bank_enable_n = (bcode[4:3] != `IDS_GRP_RIGHT);
        end
        else
        begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IN:
      begin
        nxt_state                  = ST_OUT;
        nxt_io.left_bank_enable_n  = 1'b1;
        nxt_io.right_bank_enable_n = 1'b1;
        if (op == `IDS_OP_ADD)
        begin
          nxt_carry = sum[8];
        end
        if (writes)
        begin
          if (dst_io)
          begin
            nxt_io.data                = merged;
            nxt_io.oe                  = 1'b1;
            nxt_io.write_command       = 1'b1;
            nxt_io.left_bank_enable_n  = dcode[3];
            nxt_io.right_bank_enable_n = ~dcode[3];
          end
          else if (dcode == `IDS_CODE_LB_SEL || dcode == `IDS_CODE_RB_SEL)
          begin
            nxt_io.data                  = alu;
            nxt_io.oe                    = 1'b1;
            nxt_io.select_command_strobe = 1'b1;
            nxt_io.left_bank_enable_n    = (dcode != `IDS_CODE_LB_SEL);
            nxt_io.right_bank_enable_n   = (dcode != `IDS_CODE_RB_SEL);
          end
          else if (dcode[4:3] == `IDS_GRP_LOW)
          begin
            nxt_regs[dcode[2:0]] = alu;
          end
          else if (dcode == `IDS_CODE_WREG9)
          begin
            nxt_regs[`IDS_IDX_WREG9] = alu;
          end
          // carry and unassigned codes ignore writes
        end
        nxt_pc   = 13'(pc_ff + `IDS_PC_STEP);
        nxt_addr = 13'(pc_ff + `IDS_PC_STEP);
        case (op)
          `IDS_OP_JUMP_ABS:
          begin
            nxt_pc   = instr_word[12:0];
            nxt_addr = instr_word[12:0];
          end
          `IDS_OP_EXEC_IND:
          begin
            nxt_pc   = pc_ff;
            nxt_addr = src_io ? {pc_ff[12:5], alu[4:0]} : {pc_ff[12:8], alu};
          end
          `IDS_OP_BR_NZ:
          begin
            if (sdata != `IDS_BYTE_ZERO)
            begin
              nxt_pc   = src_io ? {pc_ff[12:5], jval[4:0]} : {pc_ff[12:8], jval};
              nxt_addr = nxt_pc;
            end
          end
          default: nxt_pc = nxt_pc;
        endcase
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      pc_ff    <= `IDS_PC_RESET;
      addr_ff  <= `IDS_PC_RESET;
      carry_ff <= 1'b0;
      io_ff    <= '{data: `IDS_BYTE_ZERO, oe: 1'b0, left_bank_enable_n: 1'b1,
                    right_bank_enable_n: 1'b1, select_command_strobe: 1'b0,
                    write_command: 1'b0};
      for (int i = 0; i < 8; i++)
      begin
        regs_ff[i] <= `IDS_BYTE_ZERO;
      end
    end
    else
    begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      addr_ff  <= nxt_addr;
      carry_ff <= nxt_carry;
      io_ff    <= nxt_io;
      regs_ff  <= nxt_regs;
    end
  end

  assign prog_addr = addr_ff;
  assign io_out    = io_ff;

endmodule : ids_core
`default_nettype wire

// ---- logic/ids_params.svh ----
`ifndef IDS_PARAMS_SVH
`define IDS_PARAMS_SVH

// ==========================================================
// operation classes
`define IDS_OP_MOVE       3'h0
`define IDS_OP_ADD        3'h1
`define IDS_OP_AND        3'h2
`define IDS_OP_XOR        3'h3
`define IDS_OP_EXEC_IND   3'h4
`define IDS_OP_BR_NZ      3'h5
`define IDS_OP_LOAD_LIT   3'h6
`define IDS_OP_JUMP_ABS   3'h7

// ==========================================================
// operand codes
`define IDS_CODE_LB_SEL   5'h07
`define IDS_CODE_CARRY    5'h08
`define IDS_CODE_WREG9    5'h09
`define IDS_CODE_RB_SEL   5'h0f
`define IDS_GRP_LOW       2'h0
`define IDS_GRP_HIGH      2'h1
`define IDS_GRP_LEFT      2'h2
`define IDS_GRP_RIGHT     2'h3
`define IDS_IDX_NONE      3'h7
`define IDS_IDX_WREG9     3'h7

// ==========================================================
// apb register map
`define IDS_OFF_CTRL      12'h000
`define IDS_OFF_STATUS    12'h004
`define IDS_OFF_DATA      12'h008
`define IDS_CTRL_RUN      0

// ==========================================================
// reset values and pc step
`define IDS_PC_RESET      13'h0000
`define IDS_BYTE_ZERO     8'h00
`define IDS_WORD_ZERO     32'h0000_0000
`define IDS_PC_STEP       13'h0001

`endif

// ---- logic/ids_pkg.sv ----
`default_nettype none
package ids_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_IN   = 3'b010,
    ST_OUT  = 3'b100
  } ids_state_e;

  // i/o bus output group
  typedef struct packed {
    logic [7:0] data;
    logic       oe;
    logic       left_bank_enable_n;
    logic       right_bank_enable_n;
    logic       select_command_strobe;
    logic       write_command;
  } ids_io_s;

  function automatic logic [7:0] ids_rotr(input logic [7:0] x, input logic [2:0] k);
    logic [15:0] w;
    w = {x, x} >> k;
    return w[7:0];
  endfunction : ids_rotr

  // length code 0 means eight bits
  function automatic logic [7:0] ids_lmask(input logic [2:0] l);
    logic [2:0] n;
    n = 3'h0 - l;
    return 8'hff >> n;
  endfunction : ids_lmask

endpackage : ids_pkg
`default_nettype wire

// ---- verification/ids_core_props.sv ----
`default_nettype none
module ids_core_props
  import ids_pkg::*;
(
  // clock, reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // storage, i/o
  input wire logic [12:0] prog_addr,
  input wire logic [15:0] instr_word,
  input wire ids_io_s     io_out
);
  // ==========
  // properties
  logic xec_ff;

  // after an indirect execute the next address comes from the counter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      xec_ff <= 1'b0;
    else if ($changed(prog_addr))
      xec_ff <= ($past(instr_word[15:13]) == 3'h4);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_step;
    $changed(prog_addr) && !xec_ff;
  endsequence

  chk_apb_ready:
    assert property (psel && !penable |=> pready) else $error("no pready");
  chk_ready_once:
    assert property (pready |=> !pready) else $error("pready held");
  chk_pc_step:
    assert property (s_step ##0 ($past(instr_word[15:13]) inside {[3'h0:3'h3], 3'h6})
      |-> prog_addr == $past(prog_addr) + 13'h0001) else $error("bad step");
  chk_jump_target:
    assert property ($changed(prog_addr) && $past(instr_word[15:13]) == 3'h7
      |-> prog_addr == $past(instr_word[12:0])) else $error("bad jump");
  chk_bank_excl:
    assert property (io_out.left_bank_enable_n || io_out.right_bank_enable_n)
      else $error("both banks");
  chk_sel_pulse:
    assert property (io_out.select_command_strobe |-> io_out.oe && !io_out.write_command
      ##1 !io_out.select_command_strobe) else $error("bad select");
  chk_sel_data:
    assert property ($rose(io_out.select_command_strobe) && $past(instr_word[15:13]) == 3'h6
      |-> io_out.data == $past(instr_word[7:0])
      && io_out.left_bank_enable_n == $past(instr_word[11])) else $error("bad select data");
  chk_wr_bank:
    assert property ($rose(io_out.write_command) && $past(instr_word[15:13]) < 3'h4
      |-> io_out.oe && io_out.left_bank_enable_n == $past(instr_word[3]))
      else $error("bad write bank");
endmodule : ids_core_props
`default_nettype wire

// ---- verification/ids_mem_io.sv ----
`default_nettype none
module ids_mem_io
  import ids_pkg::*;
(
  // clock
  input  wire logic        pclk,
  // program storage
  input  wire logic [12:0] prog_addr,
  output var  logic [15:0] instr_word,
  // i/o bus
  input  wire ids_io_s     io_out,
  output var  logic [7:0]  io_in
);
  // ==========
  // storage and one device per bank
  logic [15:0] rom [8192];
  logic [7:0]  left_q   = 8'hA5;
  logic [7:0]  right_q  = 8'h00;
  logic [7:0]  left_adr = 8'h00;
  logic [7:0]  last_q   = 8'h00;

  assign instr_word = rom[prog_addr];

  // an undriven bus shows the inverse of its last level
  always_comb
    if (io_out.oe)
      io_in = io_out.data;
    else if (!io_out.left_bank_enable_n)
      io_in = left_q;
    else if (!io_out.right_bank_enable_n)
      io_in = right_q;
    else
      io_in = ~last_q;

  always @(posedge pclk)
  begin
    last_q <= io_in;
    if (io_out.write_command && !io_out.left_bank_enable_n)
      left_q <= io_out.data;
    if (io_out.write_command && !io_out.right_bank_enable_n)
      right_q <= io_out.data;
    if (io_out.select_command_strobe && !io_out.left_bank_enable_n)
      left_adr <= io_out.data;
  end
endmodule : ids_mem_io
`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none
module tb_top
  import ids_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // program image
  localparam logic [15:0] PROG [14] = '{16'hC00F, 16'hC1F0, 16'h6102, 16'h4200, 16'h0093,
    16'hC73C, 16'h1160, 16'hE009, 16'hC0EE, 16'hA00C, 16'hC0EE, 16'hC0EE, 16'h001F,
    16'hE00D};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [12:0] prog_addr;
  logic [15:0] instr_word;
  logic [7:0]  io_in;
  ids_io_s     io_out;
  int          bad_count = 0, checks = 0;

  ids_core u_ids_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .prog_addr, .instr_word, .io_in, .io_out);
  ids_mem_io u_ids_mem_io (.pclk, .prog_addr, .instr_word, .io_out, .io_in);

  always #20 pclk = ~pclk;

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; rd and err hold the answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic poll(input logic [31:0] mask, input logic [31:0] exp);
    int i;
    for (i = 0; i < 40; i++)
    begin
      apb(1'b0, 12'h004, 32'h0000_0000);
      if ((rd & mask) === exp)
        break;
    end
  endtask : poll

  initial
  begin
    foreach (u_ids_mem_io.rom[i])
      u_ids_mem_io.rom[i] = 16'hC0EE;
    foreach (PROG[i])
      u_ids_mem_io.rom[i] = PROG[i];
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(prog_addr), 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk({rd[31:1], err}, 32'h0000_0001);
    $display("test reset_map done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    poll(32'hFFFF_FFFF, 32'h800D_000D);
    chk(rd, 32'h800D_000D);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    chk(32'(u_ids_mem_io.left_q), 32'h0000_00F5);
    chk(32'(u_ids_mem_io.left_adr), 32'h0000_003C);
    chk(32'(u_ids_mem_io.right_q), 32'h0000_0007);
    $display("test program done");
    apb(1'b1, 12'h000, 32'h0000_0000);
    poll(32'h8000_0000, 32'h0000_0000);
    chk(rd & 32'h8000_0000, 32'h0000_0000);
    $display("test stop done");
    end_sim();
  end
endmodule : tb_top

bind ids_core ids_core_props u_ids_core_props (.pclk, .presetn, .psel, .penable, .pready,
  .prog_addr, .instr_word, .io_out);
`default_nettype wire
